// [common/ata_tf_pkg.sv]
// constants, types and decode codes for the task-file register port
// assumes one 250 MHz clock; all pin inputs synchronised inside the block
package ata_tf_pkg;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_ERR_FEAT = 3'h1;
    localparam logic [2:0] ADDR_SECT_CNT = 3'h2;
    localparam logic [2:0] ADDR_SECT_NUM = 3'h3;
    localparam logic [2:0] ADDR_CYL_LO = 3'h4;
    localparam logic [2:0] ADDR_CYL_HI = 3'h5;
    localparam logic [2:0] ADDR_DEV_HEAD = 3'h6;
    localparam logic [2:0] ADDR_STAT_CMD = 3'h7;
    localparam logic [2:0] ADDR_ALT_CTRL = 3'h6;
    localparam logic [3:0] OFS_DUP_EVEN = 4'h8;
    localparam logic [3:0] OFS_DUP_ODD = 4'h9;
    localparam logic [3:0] OFS_DUP_ERR_HI = 4'hC;
    localparam logic [3:0] OFS_DUP_ERR = 4'hD;
    localparam logic [7:0] RST_SECT_CNT = 8'h01;
    localparam logic [7:0] RST_SECT_NUM = 8'h01;
    localparam logic [7:0] RST_CYL_LO = 8'h00;
    localparam logic [7:0] RST_CYL_HI = 8'h00;
    localparam logic [7:0] RST_DEV_HEAD = 8'hA0;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] CMD_DIAG = 8'h90;
    localparam int DEV_BIT = 4;
    localparam int SRST_BIT = 2;
    localparam int NIEN_BIT = 1;
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_DONE_NS = 400;
    localparam int DONE_CYC = T_DONE_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_BUSY = 2'b01,
        PH_XFER = 2'b11,
        PH_WAIT = 2'b10
    } phase_t;
    typedef enum logic [3:0] {
        SEL_NONE, SEL_DATA, SEL_ERRF, SEL_SCNT, SEL_SNUM,
        SEL_CLO, SEL_CHI, SEL_DH, SEL_STAT, SEL_ALT
    } sel_t;
    typedef enum logic [1:0] {
        LANE_WORD, LANE_LO, LANE_ODD_LO, LANE_HI
    } lane_t;
endpackage

// [rtl/ata_task_file_decode.sv]
// task-file register port of a flash disk: decode, registers, busy/drq sequencing
// assumes host pins are asynchronous and slow against the 250 MHz clock
`timescale 1ns/10ps
module ata_task_file_decode
    import ata_tf_pkg::*;
#(
    parameter int WCNT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [2:0] da,
    input wire logic dior_n,
    input wire logic diow_n,
    input wire logic ce_lo_n,
    input wire logic ce_hi_n,
    input wire logic [3:0] card_addr,
    input wire logic card_rd_n,
    input wire logic card_wr_n,
    input wire logic dev_id,
    input wire logic [15:0] dd_in,
    output logic [15:0] dd_out,
    output logic dd_oe_n,
    output logic intrq,
    output logic intrq_oe_n,
    output logic busy,
    output logic drq,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] features,
    output logic [7:0] sect_cnt,
    output logic [7:0] sect_num,
    output logic [7:0] cyl_lo,
    output logic [7:0] cyl_hi,
    output logic [7:0] dev_head,
    input wire logic core_done,
    input wire logic [7:0] core_err,
    input wire logic core_block,
    input wire logic [WCNT_W-1:0] core_block_words,
    input wire logic core_last_block,
    input wire logic [15:0] data_rd,
    output logic data_rd_ack,
    output logic data_wr_valid,
    output logic [15:0] data_wr
);
    typedef struct packed {
        logic [31:0] s1;
        logic [31:0] s2;
        logic rd_prev;
        logic wr_prev;
        phase_t phase;
        logic [WCNT_W-1:0] words;
        logic [7:0] done_cnt;
        logic pend;
        logic [7:0] err;
        logic [7:0] feat;
        logic [7:0] scnt;
        logic [7:0] snum;
        logic [7:0] clo;
        logic [7:0] chi;
        logic [7:0] dh;
        logic [7:0] ctrl;
        logic [7:0] cmd;
        logic cmd_v;
        logic [7:0] even;
        logic [15:0] wdata;
        logic wvalid;
        logic rack;
        logic [15:0] dout;
        logic oe_n;
    } state_t;

    state_t st_q, st_d;

    // pin fields after the two-stage synchroniser
    logic s_cs0_n, s_cs1_n, s_dior_n, s_diow_n, s_ce_lo_n, s_ce_hi_n, s_crd_n, s_cwr_n, s_dev;
    logic [2:0] s_da;
    logic [3:0] s_ofs;
    logic [15:0] s_dd;
    assign {s_cs0_n, s_cs1_n, s_da, s_dior_n, s_diow_n, s_dd} = st_q.s2[31:9];
    assign {s_ce_lo_n, s_ce_hi_n, s_ofs, s_crd_n, s_cwr_n, s_dev} = st_q.s2[8:0];

    // task-file address to register, shared by both access paths
    function automatic sel_t cmd_sel(input logic [2:0] a);
        case (a)
            ADDR_DATA: cmd_sel = SEL_DATA;
            ADDR_ERR_FEAT: cmd_sel = SEL_ERRF;
            ADDR_SECT_CNT: cmd_sel = SEL_SCNT;
            ADDR_SECT_NUM: cmd_sel = SEL_SNUM;
            ADDR_CYL_LO: cmd_sel = SEL_CLO;
            ADDR_CYL_HI: cmd_sel = SEL_CHI;
            ADDR_DEV_HEAD: cmd_sel = SEL_DH;
            ADDR_STAT_CMD: cmd_sel = SEL_STAT;
            default: cmd_sel = SEL_NONE;
        endcase
    endfunction

    sel_t sel;
    lane_t lane;
    logic ata_acc, card_acc;
    always_comb begin
        sel = SEL_NONE;
        lane = LANE_LO;
        ata_acc = !s_cs0_n || !s_cs1_n;
        card_acc = !s_ce_lo_n || !s_ce_hi_n;
        if (ata_acc) begin
            if (!s_cs0_n && s_cs1_n) begin
                sel = cmd_sel(s_da);
                lane = (sel == SEL_DATA) ? LANE_WORD : LANE_LO;
            end else if (s_cs0_n && s_da == ADDR_ALT_CTRL) begin
                sel = SEL_ALT;
            end
            // both selects, other control addresses, and 111 stay unanswered
        end else if (card_acc) begin
            if (!s_ce_lo_n && !s_ce_hi_n) begin
                if (s_ofs[3:1] == 3'b000 || s_ofs[3:1] == OFS_DUP_EVEN[3:1]) begin
                    sel = SEL_DATA;
                    lane = LANE_WORD;
                end else if (s_ofs[3:1] == OFS_DUP_ERR_HI[3:1]) begin
                    sel = SEL_ERRF;
                    lane = LANE_HI;
                end
            end else if (!s_ce_lo_n) begin
                if (s_ofs == 4'h0 || s_ofs == OFS_DUP_EVEN) begin
                    sel = SEL_DATA;
                end else if (s_ofs == OFS_DUP_ODD) begin
                    sel = SEL_DATA;
                    lane = LANE_ODD_LO;
                end else if (s_ofs == OFS_DUP_ERR) begin
                    sel = SEL_ERRF;
                end else if (!s_ofs[3]) begin
                    sel = cmd_sel(s_ofs[2:0]);
                end
            end else begin
                lane = LANE_HI;
                if (s_ofs == OFS_DUP_EVEN || s_ofs == OFS_DUP_ODD) begin
                    sel = SEL_DATA;
                end else if (s_ofs[3:1] == 3'b000 || s_ofs[3:1] == OFS_DUP_ERR_HI[3:1]) begin
                    sel = SEL_ERRF;
                end
            end
        end
    end

    logic rd_lvl, wr_lvl, rd_end, wr_end, dev_sel, err_bit;
    logic [7:0] status, rval, wbyte;
    always_comb begin
        rd_lvl = !s_dior_n || !s_crd_n;
        wr_lvl = !s_diow_n || !s_cwr_n;
        rd_end = st_q.rd_prev && !rd_lvl;
        wr_end = st_q.wr_prev && !wr_lvl;
        dev_sel = (st_q.dh[DEV_BIT] == s_dev);
        err_bit = |st_q.err;
        status = 8'h00;
        status[ST_BSY] = (st_q.phase == PH_BUSY) || (st_q.phase == PH_WAIT);
        status[ST_DRQ] = (st_q.phase == PH_XFER);
        status[ST_DRDY] = 1'b1;
        status[ST_DSC] = 1'b1;
        status[ST_ERR] = err_bit;
        wbyte = (lane == LANE_HI) ? s_dd[15:8] : s_dd[7:0];
        case (sel)
            SEL_ERRF: rval = st_q.err;
            SEL_SCNT: rval = st_q.scnt;
            SEL_SNUM: rval = st_q.snum;
            SEL_CLO: rval = st_q.clo;
            SEL_CHI: rval = st_q.chi;
            SEL_DH: rval = st_q.dh;
            SEL_STAT: rval = status;
            SEL_ALT: rval = status;
            default: rval = 8'h00;
        endcase
    end

    always_comb begin
        st_d = st_q;
        st_d.s1 = {cs0_n, cs1_n, da, dior_n, diow_n, dd_in,
                   ce_lo_n, ce_hi_n, card_addr, card_rd_n, card_wr_n, dev_id};
        st_d.s2 = st_q.s1;
        st_d.rd_prev = rd_lvl;
        st_d.wr_prev = wr_lvl;
        st_d.cmd_v = 1'b0;
        st_d.wvalid = 1'b0;
        st_d.rack = 1'b0;
        st_d.err = core_err;
        // read data held in a flop while the strobe is low
        st_d.oe_n = 1'b1;
        st_d.dout = 16'h0000;
        if (rd_lvl && sel != SEL_NONE && dev_sel) begin
            st_d.oe_n = 1'b0;
            if (sel == SEL_DATA) begin
                case (lane)
                    LANE_WORD: st_d.dout = data_rd;
                    LANE_LO: st_d.dout = {8'h00, data_rd[7:0]};
                    LANE_ODD_LO: st_d.dout = {8'h00, data_rd[15:8]};
                    default: st_d.dout = {data_rd[15:8], 8'h00};
                endcase
            end else begin
                st_d.dout = (lane == LANE_HI) ? {rval, 8'h00} : {8'h00, rval};
            end
        end
        // data-port word completes on word access or the odd byte
        if (st_q.phase == PH_XFER && sel == SEL_DATA && dev_sel) begin
            if (rd_end && lane != LANE_LO) begin
                st_d.rack = 1'b1;
                st_d.words = st_q.words - 1'b1;
            end
            if (wr_end) begin
                if (lane == LANE_LO) begin
                    st_d.even = s_dd[7:0];
                end else begin
                    st_d.wvalid = 1'b1;
                    case (lane)
                        LANE_WORD: st_d.wdata = s_dd;
                        LANE_ODD_LO: st_d.wdata = {s_dd[7:0], st_q.even};
                        default: st_d.wdata = {s_dd[15:8], st_q.even};
                    endcase
                    st_d.words = st_q.words - 1'b1;
                end
            end
        end
        if (rd_end && sel == SEL_STAT && dev_sel) begin
            st_d.pend = 1'b0;
        end
        if (wr_end) begin
            case (sel)
                SEL_ERRF: st_d.feat = wbyte;
                SEL_SCNT: st_d.scnt = wbyte;
                SEL_SNUM: st_d.snum = wbyte;
                SEL_CLO: st_d.clo = wbyte;
                SEL_CHI: st_d.chi = wbyte;
                SEL_DH: st_d.dh = wbyte;
                SEL_ALT: st_d.ctrl = wbyte;
                SEL_STAT: begin
                    if (dev_sel) begin
                        st_d.cmd = wbyte;
                        st_d.cmd_v = 1'b1;
                        st_d.pend = 1'b0;
                        st_d.phase = PH_BUSY;
                    end
                end
                default: st_d = st_d;
            endcase
        end
        // command sequencing; busy or drq never both low while running
        case (st_q.phase)
            PH_BUSY: begin
                if (core_done) begin
                    st_d.phase = PH_IDLE;
                    st_d.pend = 1'b1;
                    if (st_q.cmd == CMD_DIAG) begin
                        st_d.scnt = RST_SECT_CNT;
                        st_d.snum = RST_SECT_NUM;
                        st_d.clo = RST_CYL_LO;
                        st_d.chi = RST_CYL_HI;
                        st_d.dh = RST_DEV_HEAD;
                    end
                end else if (core_block) begin
                    st_d.phase = PH_XFER;
                    st_d.words = core_block_words;
                    st_d.pend = 1'b1;
                end
            end
            PH_XFER: begin
                if (st_d.words == '0) begin
                    st_d.phase = core_last_block ? PH_WAIT : PH_BUSY;
                    st_d.done_cnt = 8'h00;
                end
            end
            PH_WAIT: begin
                // final status must land inside the window even if the core is late
                // margin covers two sync stages and the strobe edge detect
                st_d.done_cnt = st_q.done_cnt + 8'h01;
                if (core_done || st_q.done_cnt >= 8'(DONE_CYC - 4)) begin
                    st_d.phase = PH_IDLE;
                    st_d.pend = 1'b1;
                end
            end
            default: st_d.phase = st_d.phase;
        endcase
        if (st_q.ctrl[SRST_BIT]) begin
            st_d.phase = PH_IDLE;
            st_d.pend = 1'b0;
            st_d.scnt = RST_SECT_CNT;
            st_d.snum = RST_SECT_NUM;
            st_d.clo = RST_CYL_LO;
            st_d.chi = RST_CYL_HI;
            st_d.dh = RST_DEV_HEAD;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.s1 <= '1;
            st_q.s2 <= '1;
            st_q.phase <= PH_IDLE;
            st_q.scnt <= RST_SECT_CNT;
            st_q.snum <= RST_SECT_NUM;
            st_q.clo <= RST_CYL_LO;
            st_q.chi <= RST_CYL_HI;
            st_q.dh <= RST_DEV_HEAD;
            st_q.ctrl <= RST_CTRL;
            st_q.oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign dd_out = st_q.dout;
    assign dd_oe_n = st_q.oe_n;
    assign intrq = st_q.pend;
    assign intrq_oe_n = !(st_q.pend && dev_sel && !st_q.ctrl[NIEN_BIT]);
    assign busy = (st_q.phase == PH_BUSY) || (st_q.phase == PH_WAIT);
    assign drq = (st_q.phase == PH_XFER);
    assign cmd_valid = st_q.cmd_v;
    assign cmd_code = st_q.cmd;
    assign features = st_q.feat;
    assign sect_cnt = st_q.scnt;
    assign sect_num = st_q.snum;
    assign cyl_lo = st_q.clo;
    assign cyl_hi = st_q.chi;
    assign dev_head = st_q.dh;
    assign data_rd_ack = st_q.rack;
    assign data_wr_valid = st_q.wvalid;
    assign data_wr = st_q.wdata;
endmodule

// [verification/ata_tf_assertions.sv]
// pin-level assertions for the task-file decode block
// assumes host holds selects and address six cycles past each strobe
`timescale 1ns/10ps
module ata_tf_assertions
    import ata_tf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [2:0] da,
    input wire logic diow_n,
    input wire logic dev_id,
    input wire logic dd_oe_n,
    input wire logic intrq,
    input wire logic busy,
    input wire logic drq,
    input wire logic cmd_valid,
    input wire logic [7:0] sect_cnt,
    input wire logic [7:0] dev_head,
    input wire logic core_last_block
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // five cycles cover the two-flop sync plus the output register
    sequence no_sel;
        cs0_n && cs1_n;
    endsequence
    sequence ctrl_unused;
        cs0_n && !cs1_n && !da[2];
    endsequence
    sequence wr_taken;
        cmd_valid;
    endsequence
    AST_NO_SEL: assert property (no_sel [*5] |-> dd_oe_n)
        else $error("bus driven with no select");
    AST_CTRL_UNUSED: assert property (ctrl_unused [*5] |-> dd_oe_n)
        else $error("bus driven at unused control address");
    AST_OBSOLETE: assert property ((cs0_n && !cs1_n && da == 3'h7) [*5] |-> dd_oe_n)
        else $error("obsolete control address answered");
    AST_DEV_MISS: assert property ((dev_head[DEV_BIT] != dev_id) [*5] |-> dd_oe_n)
        else $error("read answered for other device");
    AST_CMD_BUSY: assert property (wr_taken |-> ##[0:1] (busy || drq))
        else $error("command without busy or drq");
    AST_LAST_DONE: assert property ($fell(drq) && core_last_block |-> ##[0:100] !(busy || drq))
        else $error("flags still set after last block");
    AST_INIT_VAL: assert property ($fell(rst) |-> sect_cnt == 8'h01 && dev_head == 8'hA0)
        else $error("bad initial task registers");
    AST_CMD_CLR: assert property (wr_taken |-> ##2 !intrq)
        else $error("pending kept after command write");
    AST_WR_EDGE: assert property (wr_taken |-> diow_n && $past(diow_n, 5) == 1'b0)
        else $error("command taken before strobe rise");
endmodule
bind ata_task_file_decode ata_tf_assertions u_chk (
    .clk, .rst, .cs0_n, .cs1_n, .da, .diow_n, .dev_id, .dd_oe_n, .intrq, .busy, .drq,
    .cmd_valid, .sect_cnt, .dev_head, .core_last_block
);

// [verification/ata_host_model.sv]
// host controller model on the task-file pins, one access at a time
// assumes the caller waits for idle before command block writes
`timescale 1ns/10ps
module ata_host_model (
    input wire logic clk,
    input wire logic [15:0] dd_out,
    input wire logic dd_oe_n,
    output logic cs0_n,
    output logic cs1_n,
    output logic [2:0] da,
    output logic dior_n,
    output logic diow_n,
    output logic [15:0] dd_in
);
    initial begin
        {cs1_n, cs0_n, dior_n, diow_n} = 4'hF;
        da = 3'h0;
        dd_in = 16'h5AA5;
    end
    // cs_n is {cs1_n, cs0_n}; both low is never passed
    task automatic cyc(input logic wr, input logic [1:0] cs_n, input logic [2:0] a,
            input logic [15:0] wd, output logic [15:0] rd, output logic oe_n);
        @(negedge clk);
        {cs1_n, cs0_n} <= cs_n;
        da <= a;
        dd_in <= wr ? wd : ~dd_in;
        @(negedge clk);
        dior_n <= wr;
        diow_n <= !wr;
        repeat (6) @(negedge clk);
        rd = dd_out;
        oe_n = dd_oe_n;
        {dior_n, diow_n} <= 2'b11;
        // hold past the rising edge, the device latches late through its sync
        repeat (6) @(negedge clk);
        {cs1_n, cs0_n} <= 2'b11;
        dd_in <= ~dd_in;
        @(negedge clk);
    endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench: host model on the pins, bench drives the core side
// assumes the checker is bound into the design from its own file
`timescale 1ns/10ps
module tb_top;
    import ata_tf_pkg::*;
    logic clk, rst, cs0_n, cs1_n, dior_n, diow_n, dev_id, dd_oe_n, intrq, busy, drq;
    logic core_done, core_block, core_last_block, oe_n;
    logic [2:0] da;
    logic [7:0] core_err, dev_head;
    logic [15:0] dd_in, dd_out, data_rd, core_block_words, rd, exp_w, alt;
    logic [7:0] model [2:6];
    int mismatches, checked, seed, k;
    ata_host_model host (.clk, .dd_out, .dd_oe_n, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dd_in);
    ata_task_file_decode u_ata_task_file_decode (
        .clk, .rst, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .ce_lo_n(1'b1), .ce_hi_n(1'b1),
        .card_addr(4'h0), .card_rd_n(1'b1), .card_wr_n(1'b1), .dev_id, .dd_in, .dd_out,
        .dd_oe_n, .intrq, .intrq_oe_n(), .busy, .drq, .cmd_valid(), .cmd_code(), .features(),
        .sect_cnt(), .sect_num(), .cyl_lo(), .cyl_hi(), .dev_head, .core_done, .core_err,
        .core_block, .core_block_words, .core_last_block, .data_rd, .data_rd_ack(),
        .data_wr_valid(), .data_wr()
    );
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic rd_at(input logic [1:0] cs_n, input logic [2:0] a);
        host.cyc(1'b0, cs_n, a, 16'h0000, rd, oe_n);
    endtask
    task automatic wr_at(input logic [1:0] cs_n, input logic [2:0] a, input logic [15:0] w);
        host.cyc(1'b1, cs_n, a, w, rd, oe_n);
    endtask
    // device-select bit kept clear so this device stays addressed
    task automatic write_random;
        logic [15:0] w;
        for (int i = 2; i <= 6; i++) begin
            w = 16'($random(seed));
            if (i == 6) w[DEV_BIT] = 1'b0;
            model[i] = w[7:0];
            wr_at(2'b10, 3'(i), w);
        end
    endtask
    task automatic verify_regs;
        for (int i = 2; i <= 6; i++) begin
            rd_at(2'b10, 3'(i));
            check("task reg", {8'h00, rd[7:0]}, {8'h00, model[i]});
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        seed = 32'h7848AFE7;
        {rst, dev_id, core_done, core_block, core_last_block} = 5'h10;
        core_err = 8'h00;
        data_rd = 16'h0000;
        core_block_words = 16'h0000;
        mismatches = 0;
        checked = 0;
        model = '{8'h01, 8'h01, 8'h00, 8'h00, 8'hA0};
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        verify_regs();
        write_random();
        wr_at(2'b01, 3'h0, 16'hFFFF);
        wr_at(2'b11, 3'h3, 16'hFFFF);
        wr_at(2'b01, ADDR_ALT_CTRL, 16'h0000);
        verify_regs();
        core_err = 8'($random(seed));
        rd_at(2'b10, ADDR_ERR_FEAT);
        check("error", {8'h00, rd[7:0]}, {8'h00, core_err});
        rd_at(2'b11, 3'h2);
        check("oe no select", {15'h0000, oe_n}, 16'h0001);
        rd_at(2'b01, 3'h7);
        check("oe obsolete", {15'h0000, oe_n}, 16'h0001);
        dev_id = 1'b1;
        rd_at(2'b10, ADDR_SECT_CNT);
        check("oe other device", {15'h0000, oe_n}, 16'h0001);
        dev_id = 1'b0;
        wr_at(2'b10, ADDR_STAT_CMD, 16'h0020);
        check("busy", {14'h0000, busy, drq}, 16'h0002);
        {core_block, core_last_block} = 2'b11;
        core_block_words = 16'h0002;
        @(negedge clk);
        core_block = 1'b0;
        @(negedge clk);
        check("drq", {13'h0000, intrq, busy, drq}, 16'h0005);
        for (k = 0; k < 2; k++) begin
            exp_w = 16'($random(seed));
            data_rd = exp_w;
            rd_at(2'b10, ADDR_DATA);
            check("data word", rd, exp_w);
        end
        repeat (98) @(negedge clk);
        check("done", {14'h0000, busy, drq}, 16'h0000);
        rd_at(2'b01, ADDR_ALT_CTRL);
        alt = rd;
        check("pend kept", {15'h0000, intrq}, 16'h0001);
        rd_at(2'b10, ADDR_STAT_CMD);
        check("alt status", {8'h00, alt[7:0]}, {8'h00, rd[7:0]});
        check("pend cleared", {15'h0000, intrq}, 16'h0000);
        write_random();
        wr_at(2'b10, ADDR_STAT_CMD, {8'h00, CMD_DIAG});
        core_done = 1'b1;
        @(negedge clk);
        core_done = 1'b0;
        model = '{8'h01, 8'h01, 8'h00, 8'h00, 8'hA0};
        repeat (2) @(negedge clk);
        verify_regs();
        tally_and_finish();
    end
endmodule
